// *** testbench/framer_interrupt_enable_mask_properties.sv ***
`timescale 1ns/1ps
`include "irq_enable_cfg.svh"
module irq_mask_checker
    import irq_enable_pkg::*;
(
    // clock and reset
    input wire logic          clk,
    input wire logic          rst_n,
    // host port
    input wire host_req_type  host_req,
    input wire logic [7:0]    host_rdata,
    input wire logic          host_rvalid,
    // events and status
    input wire irq_group_type event_pulse,
    input wire irq_group_type status_clear,
    input wire irq_group_type irq_status_bit,
    input wire logic [7:0]    master_irq_bit
);
    logic [7:0] any_set;
    always_comb begin
        for (int g = 0; g < 8; g++) any_set[g] = |irq_status_bit[g*8 +: 8];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (host_rvalid == $past(host_req.read))
        else $error("read answer timing wrong");
    a_rdata_idle: assert property (!host_rvalid |-> host_rdata == 8'h00)
        else $error("read data not idle");
    a_status_set: assert property ((irq_status_bit & $past(event_pulse))
        == $past(event_pulse))
        else $error("event did not set status");
    a_status_hold: assert property (($past(irq_status_bit) & ~$past(status_clear)
        & ~irq_status_bit) == 64'h0)
        else $error("status lost without clear");
    a_master_cause: assert property ((master_irq_bit & ~$past(any_set)) == 8'h00)
        else $error("master without status");
    a_rsvd_alarm: assert property (host_rvalid && $past(host_req.addr) == `OFS_ALARM_TWO
        |-> (host_rdata & ~`MASK_ALARM_TWO) == 8'h00)
        else $error("reserved alarm bits set");
    a_rsvd_pattern: assert property (host_rvalid && $past(host_req.addr) == `OFS_PATTERN
        |-> host_rdata[7:6] == 2'h0)
        else $error("reserved pattern bits set");
    a_unmapped_zero: assert property (host_rvalid && $past(host_req.addr) > `OFS_PATTERN
        |-> host_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : irq_mask_checker

bind framer_interrupt_enable_mask irq_mask_checker u_chk (.clk(clk), .rst_n(rst_n),
    .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .event_pulse(event_pulse), .status_clear(status_clear),
    .irq_status_bit(irq_status_bit), .master_irq_bit(master_irq_bit));

// *** testbench/framer_interrupt_enable_mask_test.sv ***
`timescale 1ns/1ps
`include "irq_enable_cfg.svh"
module framer_interrupt_enable_mask_test
    import irq_enable_pkg::*;
    ;
    logic clk = 1'b0, rst_n = 1'b0, host_rvalid, tick = 1'b0, latch = 1'b0;
    logic [7:0] host_rdata, master_irq_bit, inc = '0, rd_lo = '0, rd_hi = '0;
    host_req_type host_req;
    irq_group_type event_pulse = '0, status_clear = '0, irq_status_bit;
    logic [7:0][15:0] count_value;
    logic [7:0] expect_q[$];
    logic [7:0] en [8];
    int bad_count = 0, samples_checked = 0, seed = 32'h8df87259;
    always #2.5 clk = ~clk;
    irq_host_model host (.clk(clk), .host_req(host_req));
    framer_interrupt_enable_mask #(.NUM_COUNTERS(8)) DUT (.clk(clk), .rst_n(rst_n),
        .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .event_pulse(event_pulse), .count_inc(inc), .one_second_tick(tick),
        .counter_latch_mode(latch), .count_read_low(rd_lo), .count_read_high(rd_hi),
        .count_value(count_value), .status_clear(status_clear),
        .irq_status_bit(irq_status_bit), .master_irq_bit(master_irq_bit));
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic read_expect(input logic [8:0] a, input logic [7:0] v);
        expect_q.push_back(v);
        host.rd(a);
    endtask : read_expect
    always @(negedge clk) begin
        if (host_rvalid === 1'b1 && expect_q.size() > 0) check(host_rdata, expect_q.pop_front());
    end
    initial begin
        logic [8:0] a;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 8; i++) begin
                a = `OFS_ALARM_ONE + 9'(i);
                if (r == 0) read_expect(a, 8'h00);
                en[i] = (i % 2 == r) ? 8'h00 : 8'($random(seed)) & host.keep_mask(a);
                host.wr(a, en[i]);
                read_expect(a, en[i]);
            end
            read_expect(9'h014, 8'h00);
            @(negedge clk) event_pulse = '1;
            @(negedge clk) event_pulse = '0;
            repeat (2) @(negedge clk);
            check(irq_status_bit, '1);
            for (int i = 0; i < 8; i++) check(master_irq_bit[7-i], |en[i]);
            @(negedge clk) status_clear = '1;
            @(negedge clk) status_clear = '0;
            repeat (2) @(negedge clk);
            check(master_irq_bit, 8'h00);
        end
        // counter zero rolls over, counter one saturates
        host.wr(`OFS_OVERFLOW, 8'h01);
        @(negedge clk) inc = 8'h03;
        repeat (65537) @(negedge clk);
        inc = 8'h00;
        @(negedge clk) rd_lo = 8'h03;
        @(negedge clk) rd_lo = 8'h00;
        @(negedge clk);
        check(count_value[0], 16'h0001);
        check(count_value[1], 16'hffff);
        check(irq_status_bit.overflow, 8'h01);
        check(master_irq_bit[4], 1'b1);
        @(negedge clk) rd_hi = 8'h03;
        @(negedge clk) rd_hi = 8'h00;
        @(negedge clk) rd_lo = 8'h03;
        @(negedge clk) rd_lo = 8'h00;
        @(negedge clk);
        check(count_value[1], 16'h0000);
        // latch mode: a high-byte read mid-count must not clear
        @(negedge clk) latch = 1'b1;
        inc = 8'h03;
        @(negedge clk) rd_hi = 8'h03;
        @(negedge clk) rd_hi = 8'h00;
        @(negedge clk) inc = 8'h00;
        tick = 1'b1;
        @(negedge clk) tick = 1'b0;
        @(negedge clk) rd_lo = 8'h03;
        @(negedge clk) rd_lo = 8'h00;
        @(negedge clk);
        check(count_value[0], 16'h0003);
        check(count_value[1], 16'h0003);
        for (int t = 0; t < 20 && expect_q.size() > 0; t++) @(negedge clk);
        if (expect_q.size() > 0) bad_count++;
        results();
    end
endmodule : framer_interrupt_enable_mask_test

// *** testbench/irq_host_model.sv ***
`timescale 1ns/1ps
`include "irq_enable_cfg.svh"
module irq_host_model
    import irq_enable_pkg::*;
(
    // clock
    input  wire logic   clk,
    // register requests
    output host_req_type host_req
);
    initial host_req = '0;

    function automatic logic [7:0] keep_mask(input logic [8:0] a);
        if (a == `OFS_ALARM_TWO) return `MASK_ALARM_TWO;
        if (a == `OFS_ERROR) return `MASK_ERROR;
        if (a == `OFS_PATTERN) return `MASK_PATTERN;
        return `MASK_FULL;
    endfunction : keep_mask

    // reserved bits always written low
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge clk) host_req <= '{1'b1, 1'b0, a, d & keep_mask(a)};
        @(negedge clk) host_req <= '0;
    endtask : wr

    task automatic rd(input logic [8:0] a);
        @(negedge clk) host_req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk) host_req <= '0;
    endtask : rd
endmodule : irq_host_model

// *** verilog/framer_interrupt_enable_mask.sv ***
`timescale 1ns/1ps
`include "irq_enable_cfg.svh"
module framer_interrupt_enable_mask
    import irq_enable_pkg::*;
#(
    parameter int NUM_COUNTERS = 8
) (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    // host register port
    input  wire host_req_type                     host_req,
    output logic [7:0]                            host_rdata,
    output logic                                  host_rvalid,
    // event sources
    input  wire irq_group_type                    event_pulse,
    input  wire logic [NUM_COUNTERS-1:0]          count_inc,
    input  wire logic                             one_second_tick,
    input  wire logic                             counter_latch_mode,
    // counter read strobes from host
    input  wire logic [NUM_COUNTERS-1:0]          count_read_low,
    input  wire logic [NUM_COUNTERS-1:0]          count_read_high,
    output logic [NUM_COUNTERS-1:0][`CNT_W-1:0]   count_value,
    // status and master interrupt
    input  wire irq_group_type                    status_clear,
    output irq_group_type                         irq_status_bit,
    output logic [`NUM_GROUPS-1:0]                master_irq_bit
);

    // ****************************************************************
    // enable registers
    // ****************************************************************
    irq_group_type irq_enable_bit;
    logic [7:0]    en_alarm_one;
    logic [7:0]    en_alarm_two;
    logic [7:0]    en_error;
    logic [7:0]    en_overflow;
    logic [7:0]    en_timer;
    logic [7:0]    en_link_one;
    logic [7:0]    en_link_two;
    logic [7:0]    en_pattern;
    logic          wr_alarm_one;
    logic          wr_alarm_two;
    logic          wr_error;
    logic          wr_overflow;
    logic          wr_timer;
    logic          wr_link_one;
    logic          wr_link_two;
    logic          wr_pattern;

    // ****************************************************************
    // write decode
    // ****************************************************************
    // unmapped offsets raise no strobe, so those writes are dropped
    always_comb begin
        wr_alarm_one = host_req.write && (host_req.addr == `OFS_ALARM_ONE);
        wr_alarm_two = host_req.write && (host_req.addr == `OFS_ALARM_TWO);
        wr_error     = host_req.write && (host_req.addr == `OFS_ERROR);
        wr_overflow  = host_req.write && (host_req.addr == `OFS_OVERFLOW);
        wr_timer     = host_req.write && (host_req.addr == `OFS_TIMER);
        wr_link_one  = host_req.write && (host_req.addr == `OFS_LINK_ONE);
        wr_link_two  = host_req.write && (host_req.addr == `OFS_LINK_TWO);
        wr_pattern   = host_req.write && (host_req.addr == `OFS_PATTERN);
    end

    // ****************************************************************
    // enable storage
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_alarm_one <= `ENABLE_RESET;
        end else if (wr_alarm_one) begin
            en_alarm_one <= host_req.wdata; // RULE3 RULE16
        end
    end

    // reserved bits always store zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_alarm_two <= `ENABLE_RESET;
        end else if (wr_alarm_two) begin
            en_alarm_two <= host_req.wdata & `MASK_ALARM_TWO; // RULE4 RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_error <= `ENABLE_RESET;
        end else if (wr_error) begin
            en_error <= host_req.wdata & `MASK_ERROR; // RULE6 RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_overflow <= `ENABLE_RESET;
        end else if (wr_overflow) begin
            en_overflow <= host_req.wdata; // RULE7 RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_timer <= `ENABLE_RESET;
        end else if (wr_timer) begin
            en_timer <= host_req.wdata; // RULE12 RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_link_one <= `ENABLE_RESET;
        end else if (wr_link_one) begin
            en_link_one <= host_req.wdata; // RULE13 RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_link_two <= `ENABLE_RESET;
        end else if (wr_link_two) begin
            en_link_two <= host_req.wdata; // RULE14 RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_pattern <= `ENABLE_RESET;
        end else if (wr_pattern) begin
            en_pattern <= host_req.wdata & `MASK_PATTERN; // RULE15 RULE16
        end
    end

    // ****************************************************************
    // enable view
    // ****************************************************************
    always_comb begin
        irq_enable_bit.alarm_one = en_alarm_one;
        irq_enable_bit.alarm_two = en_alarm_two;
        irq_enable_bit.error     = en_error;
        irq_enable_bit.overflow  = en_overflow;
        irq_enable_bit.timer     = en_timer;
        irq_enable_bit.link_one  = en_link_one;
        irq_enable_bit.link_two  = en_link_two;
        irq_enable_bit.pattern   = en_pattern;
    end

    // ****************************************************************
    // register read back
    // ****************************************************************
    logic [7:0] next_rdata;

    always_comb begin
        unique case (host_req.addr)
            `OFS_ALARM_ONE: next_rdata = irq_enable_bit.alarm_one;
            `OFS_ALARM_TWO: next_rdata = irq_enable_bit.alarm_two;
            `OFS_ERROR:     next_rdata = irq_enable_bit.error;
            `OFS_OVERFLOW:  next_rdata = irq_enable_bit.overflow;
            `OFS_TIMER:     next_rdata = irq_enable_bit.timer;
            `OFS_LINK_ONE:  next_rdata = irq_enable_bit.link_one;
            `OFS_LINK_TWO:  next_rdata = irq_enable_bit.link_two;
            `OFS_PATTERN:   next_rdata = irq_enable_bit.pattern;
            default:        next_rdata = `ENABLE_RESET;
        endcase
    end

    // data idles at zero outside a read answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_rdata <= `ENABLE_RESET;
        end else begin
            host_rdata <= host_req.read ? next_rdata : `ENABLE_RESET; // RULE16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_req.read; // RULE16
        end
    end

    // ****************************************************************
    // event counters
    // ****************************************************************
    logic [NUM_COUNTERS-1:0] rollover;

    genvar i;
    generate
        for (i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
            event_counter #(
                .WIDTH (`CNT_W)
            ) u_counter (
                .clk         (clk),
                .rst_n       (rst_n),
                .inc         (count_inc[i]),
                .tick        (one_second_tick),
                .latch_mode  (counter_latch_mode),
                .read_low    (count_read_low[i]),
                .read_high   (count_read_high[i]),
                .overflow_en (irq_enable_bit.overflow[i]),
                .value       (count_value[i]),
                .rollover    (rollover[i])
            );
        end
    endgenerate

    // ****************************************************************
    // status and master interrupt
    // ****************************************************************
    irq_group_type                  set_vec;
    logic [`NUM_GROUPS*`GROUP_W-1:0] set_flat;
    logic [`NUM_GROUPS*`GROUP_W-1:0] clear_flat;
    logic [`NUM_GROUPS*`GROUP_W-1:0] en_flat;
    logic [`NUM_GROUPS*`GROUP_W-1:0] status_flat;

    always_comb begin
        set_vec          = event_pulse;
        // enabled rollover also sets the overflow status
        set_vec.overflow = event_pulse.overflow | `GROUP_W'(rollover);
        set_flat         = set_vec;
        clear_flat       = status_clear;
        en_flat          = irq_enable_bit;
    end

    // group seven is alarm one, group zero is pattern
    genvar g;
    generate
        for (g = 0; g < `NUM_GROUPS; g++) begin : g_grp
            irq_group_cell #(
                .WIDTH (`GROUP_W)
            ) u_cell (
                .clk    (clk),
                .rst_n  (rst_n),
                .set    (set_flat[g*`GROUP_W +: `GROUP_W]),
                .clear  (clear_flat[g*`GROUP_W +: `GROUP_W]),
                .enable (en_flat[g*`GROUP_W +: `GROUP_W]),
                .status (status_flat[g*`GROUP_W +: `GROUP_W]),
                .master (master_irq_bit[g])
            );
        end
    endgenerate

    assign irq_status_bit = status_flat;

endmodule : framer_interrupt_enable_mask

// ****************************************************************
// event counter, saturating or rolling over
// ****************************************************************
module event_counter #(
    parameter int WIDTH = `CNT_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // count and latch control
    input  wire logic             inc,
    input  wire logic             tick,
    input  wire logic             latch_mode,
    input  wire logic             read_low,
    input  wire logic             read_high,
    input  wire logic             overflow_en,
    // snapshot and rollover
    output logic [WIDTH-1:0]      value,
    output logic                  rollover
);

    logic [WIDTH-1:0] count_run;
    logic [WIDTH-1:0] count_start;
    logic             at_max;
    logic             clr;

    always_comb begin
        at_max      = (count_run == {WIDTH{1'b1}});
        count_start = inc ? WIDTH'(1) : '0;
        // read clear only without latch mode
        clr         = read_high && !latch_mode; // RULE8 RULE9
        // only an enabled counter reports rollover
        rollover    = inc && at_max && overflow_en; // RULE9 RULE11
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_run <= '0;
        end else if (latch_mode && tick) begin
            count_run <= count_start; // RULE10 RULE11
        end else if (clr) begin
            count_run <= count_start; // RULE8 RULE9
        end else if (inc && (!at_max || overflow_en)) begin
            count_run <= count_run + WIDTH'(1); // RULE8 RULE9 RULE10 RULE11
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value <= '0;
        end else if (latch_mode ? tick : read_low) begin
            value <= count_run; // RULE8 RULE10
        end
    end

endmodule : event_counter

// ****************************************************************
// sticky status and master bit of one group
// ****************************************************************
module irq_group_cell #(
    parameter int WIDTH = `GROUP_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // per-source set, clear and enable
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clear,
    input  wire logic [WIDTH-1:0] enable,
    // sticky status and master bit
    output logic [WIDTH-1:0]      status,
    output logic                  master
);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            // set wins over clear
            status <= (status & ~clear) | set; // RULE1 RULE2
        end
    end

    // disabled sources never reach the master bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            master <= 1'b0;
        end else begin
            master <= |(status & enable); // RULE1 RULE2 RULE8 RULE10
        end
    end

endmodule : irq_group_cell

// *** verilog/irq_enable_cfg.svh ***
`ifndef IRQ_ENABLE_CFG_SVH
`define IRQ_ENABLE_CFG_SVH
// Operation
// RULE1: enabled source sets status and master bit
// RULE2: disabled source sets status, never master
// RULE3: alarm one enables at 00c
// RULE4: alarm two enables at 00d, bits 4,2 reserved
// RULE5: host writes zero to reserved bits
// RULE6: error enables at 00e
// RULE7: counter overflow enables at 00f
// RULE8: no overflow, no latch: saturate, read-clear
// RULE9: overflow, no latch: rollover raises master
// RULE10: latch mode: tick latch, saturate, no clear
// RULE11: latch plus overflow: tick latch, rollover irq
// RULE12: frame timer enables at 010
// RULE13: link one enables at 011
// RULE14: link two enables at 012
// RULE15: pattern enables at 013, bits 7,6 reserved
// RULE16: enable registers read back last write
`define ADDR_W           9
`define OFS_ALARM_ONE    9'h00c
`define OFS_ALARM_TWO    9'h00d
`define OFS_ERROR        9'h00e
`define OFS_OVERFLOW     9'h00f
`define OFS_TIMER        9'h010
`define OFS_LINK_ONE     9'h011
`define OFS_LINK_TWO     9'h012
`define OFS_PATTERN      9'h013
`define MASK_ALARM_TWO   8'heb
`define MASK_ERROR       8'hcf
`define MASK_PATTERN     8'h3f
`define MASK_FULL        8'hff
`define ENABLE_RESET     8'h00
`define NUM_GROUPS       8
`define GROUP_W          8
`define CNT_W            16
`define CNT_MAX          16'hffff
`define CNT_ZERO         16'h0000
`endif

// *** verilog/irq_enable_pkg.sv ***
package irq_enable_pkg;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [8:0] addr;
        logic [7:0] wdata;
    } host_req_type;

    typedef struct packed {
        logic [7:0] alarm_one;
        logic [7:0] alarm_two;
        logic [7:0] error;
        logic [7:0] overflow;
        logic [7:0] timer;
        logic [7:0] link_one;
        logic [7:0] link_two;
        logic [7:0] pattern;
    } irq_group_type;
endpackage : irq_enable_pkg
